// ### logic/scg_pkg.sv
// constants of the system clock select and gating block
package scg_pkg;
   // register byte addresses
   localparam logic [31:0] SCG_BASE          = 32'h4004_8000;
   localparam logic [31:0] SCG_OFF_PLL_CHOICE = 32'h4004_8040;
   localparam logic [31:0] SCG_OFF_PLL_UPDATE = 32'h4004_8044;
   localparam logic [31:0] SCG_OFF_MAIN_CHOICE = 32'h4004_8070;
   localparam logic [31:0] SCG_OFF_MAIN_UPDATE = 32'h4004_8074;
   localparam logic [31:0] SCG_OFF_SYS_DIV    = 32'h4004_8078;
   localparam logic [31:0] SCG_OFF_GATES      = 32'h4004_8080;

   // field positions and widths
   localparam int SCG_SEL_LSB    = 0;
   localparam int SCG_SEL_W      = 2;
   localparam int SCG_UPD_BIT    = 0;
   localparam int SCG_DIV_LSB    = 0;
   localparam int SCG_DIV_W      = 8;
   localparam int SCG_GATE_SYS   = 0;
   localparam int SCG_GATE_ROM   = 1;
   localparam int SCG_GATE_RAM   = 2;
   localparam int SCG_GATE_FLASH = 3;
   localparam int SCG_GATE_W     = 4;

   // reset values
   localparam logic [1:0] SCG_PLL_CHOICE_RST  = 2'h0;
   localparam logic       SCG_UPDATE_RST      = 1'b0;
   localparam logic [1:0] SCG_MAIN_CHOICE_RST = 2'h0;
   localparam logic [7:0] SCG_SYS_DIV_RST     = 8'h01;
   localparam logic [3:1] SCG_GATES_RST       = 3'h7;

   // source codes
   localparam logic [1:0] SCG_PLL_SRC_RC     = 2'h0;
   localparam logic [1:0] SCG_PLL_SRC_SYSOSC = 2'h1;
   localparam logic [1:0] SCG_MAIN_SRC_RC    = 2'h0;
   localparam logic [1:0] SCG_MAIN_SRC_PLLIN = 2'h1;
   localparam logic [1:0] SCG_MAIN_SRC_WD    = 2'h2;
   localparam logic [1:0] SCG_MAIN_SRC_PLLOUT = 2'h3;
endpackage

// ### logic/scg_divider.sv
// main clock to system clock divider, tick based, period-aligned
`timescale 1ns/1ps
`default_nettype none
module scg_divider
   import scg_pkg::*;
#(
   parameter int              W     = SCG_DIV_W,
   parameter logic [W-1:0]    RST_N = W'(SCG_SYS_DIV_RST)
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         tick_i,
   input  wire logic [W-1:0] div_i,
   output logic              tick_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] active;
      logic         tick;
   } scg_div_s;

   scg_div_s st;
   scg_div_s next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.active == '0) begin
         // stopped: no tick at all, pick up a new ratio at once
         next_st.cnt = '0;
         next_st.active = div_i;
      end else if (tick_i) begin
         if (st.cnt == W'(st.active - 1'b1)) begin
            // new ratio only at a period boundary, no short phase
            next_st.tick = 1'b1;
            next_st.cnt = '0;
            next_st.active = div_i;
         end else begin
            next_st.cnt = W'(st.cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.cnt <= '0;
         st.active <= RST_N;
         st.tick <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;
endmodule
`default_nettype wire

// ### logic/scg_top.sv
// clock source selection, system clock divider and block clock gates
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module scg_top
   import scg_pkg::*;
#(
   parameter int DIV_W = SCG_DIV_W
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // classic wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // rising-edge ticks of the source clocks
   input  wire logic        rc_osc_tick_i,
   input  wire logic        sys_osc_tick_i,
   input  wire logic        wd_osc_tick_i,
   input  wire logic        pll_out_tick_i,
   // applied selections
   output logic [1:0]       pll_src_o,
   output logic [1:0]       main_src_o,
   // derived clock ticks
   output logic             pll_in_tick_o,
   output logic             main_tick_o,
   output logic             sys_tick_o,
   output logic             core_tick_o,
   output logic             rom_tick_o,
   output logic             ram_tick_o,
   output logic             flash_reg_tick_o
);
   typedef struct packed {
      logic [1:0]       pll_input_choice;
      logic             pll_update_request_bit;
      logic [1:0]       pll_src;
      logic [1:0]       main_clock_choice;
      logic             main_update_request_bit;
      logic [1:0]       main_src;
      logic [DIV_W-1:0] system_clock_divider;
      logic [3:1]       block_clock_gates;
      logic             ack;
      logic [31:0]      dat;
      logic             pll_in_tick;
      logic             main_tick;
      logic             core_tick;
      logic             rom_tick;
      logic             ram_tick;
      logic             flash_reg_tick;
   } scg_state_s;

   scg_state_s st;
   scg_state_s next_st;
   logic       sys_tick;

   // read value of one register, zero for reserved bits and holes
   function automatic logic [31:0] rd_word(input logic [31:0] adr,
                                           input scg_state_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (adr)
         SCG_OFF_PLL_CHOICE:  w[SCG_SEL_LSB +: SCG_SEL_W] =
                                 s.pll_input_choice;
         SCG_OFF_PLL_UPDATE:  w[SCG_UPD_BIT] = s.pll_update_request_bit;
         SCG_OFF_MAIN_CHOICE: w[SCG_SEL_LSB +: SCG_SEL_W] =
                                 s.main_clock_choice;
         SCG_OFF_MAIN_UPDATE: w[SCG_UPD_BIT] = s.main_update_request_bit;
         SCG_OFF_SYS_DIV:     w[SCG_DIV_LSB +: DIV_W] =
                                 s.system_clock_divider;
         SCG_OFF_GATES: begin
            w[SCG_GATE_SYS] = 1'b1;
            w[SCG_GATE_FLASH:SCG_GATE_ROM] = s.block_clock_gates;
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // source tick for a main clock code
   function automatic logic main_pick(input logic [1:0] code,
                                      input logic pll_in,
                                      input logic rc,
                                      input logic wd,
                                      input logic pll_out);
      logic t;
      t = 1'b0;
      case (code)
         SCG_MAIN_SRC_RC:     t = rc;
         SCG_MAIN_SRC_PLLIN:  t = pll_in;
         SCG_MAIN_SRC_WD:     t = wd;
         SCG_MAIN_SRC_PLLOUT: t = pll_out;
         default:             t = 1'b0;
      endcase
      return t;
   endfunction

   logic req;
   logic wr0;

   always_comb begin
      req = wb_cyc_i && wb_stb_i && !st.ack;
      // only byte lane 0 carries fields
      wr0 = req && wb_we_i && wb_sel_i[0];
      next_st = st;
      next_st.ack = req;
      next_st.dat = 32'h0000_0000;
      if (req && !wb_we_i) begin
         next_st.dat = rd_word(wb_adr_i, st);
      end

      if (wr0) begin
         case (wb_adr_i)
            SCG_OFF_PLL_CHOICE: begin
               // stored only; the running input is unchanged
               next_st.pll_input_choice =
                  wb_dat_i[SCG_SEL_LSB +: SCG_SEL_W];
            end
            SCG_OFF_PLL_UPDATE: begin
               next_st.pll_update_request_bit =
                  wb_dat_i[SCG_UPD_BIT];
               if (!st.pll_update_request_bit &&
                   wb_dat_i[SCG_UPD_BIT]) begin
                  next_st.pll_src = st.pll_input_choice;
               end
            end
            SCG_OFF_MAIN_CHOICE: begin
               next_st.main_clock_choice =
                  wb_dat_i[SCG_SEL_LSB +: SCG_SEL_W];
            end
            SCG_OFF_MAIN_UPDATE: begin
               next_st.main_update_request_bit =
                  wb_dat_i[SCG_UPD_BIT];
               if (!st.main_update_request_bit &&
                   wb_dat_i[SCG_UPD_BIT]) begin
                  next_st.main_src = st.main_clock_choice;
               end
            end
            SCG_OFF_SYS_DIV: begin
               next_st.system_clock_divider =
                  wb_dat_i[SCG_DIV_LSB +: DIV_W];
            end
            SCG_OFF_GATES: begin
               // bit 0 is read only and not stored
               next_st.block_clock_gates =
                  wb_dat_i[SCG_GATE_FLASH:SCG_GATE_ROM];
            end
            default: ;
         endcase
      end

      // reserved input codes give no clock at all
      case (st.pll_src)
         SCG_PLL_SRC_RC:     next_st.pll_in_tick = rc_osc_tick_i;
         SCG_PLL_SRC_SYSOSC: next_st.pll_in_tick = sys_osc_tick_i;
         default:            next_st.pll_in_tick = 1'b0;
      endcase

      // whole source edges only are forwarded, so a switch between
      // ticks never cuts a phase short
      next_st.main_tick = main_pick(st.main_src, st.pll_in_tick,
                                    rc_osc_tick_i, wd_osc_tick_i,
                                    pll_out_tick_i);

      // gates act on whole system ticks
      next_st.core_tick = sys_tick;
      next_st.rom_tick = sys_tick &&
                         st.block_clock_gates[SCG_GATE_ROM];
      next_st.ram_tick = sys_tick &&
                         st.block_clock_gates[SCG_GATE_RAM];
      next_st.flash_reg_tick = sys_tick &&
                         st.block_clock_gates[SCG_GATE_FLASH];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.pll_input_choice <= SCG_PLL_CHOICE_RST;
         st.pll_update_request_bit <= SCG_UPDATE_RST;
         st.pll_src <= SCG_PLL_CHOICE_RST;
         st.main_clock_choice <= SCG_MAIN_CHOICE_RST;
         st.main_update_request_bit <= SCG_UPDATE_RST;
         st.main_src <= SCG_MAIN_CHOICE_RST;
         st.system_clock_divider <= DIV_W'(SCG_SYS_DIV_RST);
         st.block_clock_gates <= SCG_GATES_RST;
         st.ack <= 1'b0;
         st.dat <= 32'h0000_0000;
         st.pll_in_tick <= 1'b0;
         st.main_tick <= 1'b0;
         st.core_tick <= 1'b0;
         st.rom_tick <= 1'b0;
         st.ram_tick <= 1'b0;
         st.flash_reg_tick <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   scg_divider #(
      .W     (DIV_W),
      .RST_N (DIV_W'(SCG_SYS_DIV_RST))
   ) u_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (st.main_tick),
      .div_i  (st.system_clock_divider),
      .tick_o (sys_tick)
   );

   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign pll_src_o = st.pll_src;
   assign main_src_o = st.main_src;
   assign pll_in_tick_o = st.pll_in_tick;
   assign main_tick_o = st.main_tick;
   assign sys_tick_o = sys_tick;
   assign core_tick_o = st.core_tick;
   assign rom_tick_o = st.rom_tick;
   assign ram_tick_o = st.ram_tick;
   assign flash_reg_tick_o = st.flash_reg_tick;
endmodule
`default_nettype wire

// ### dv/scg_top_asserts.sv
// port-level checks of the clock select and gating block
`timescale 1ns/1ps
`default_nettype none
module scg_top_asserts #(
   parameter int DIV_W = 8
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rc_osc_tick_i,
   input wire logic        wd_osc_tick_i,
   input wire logic [1:0]  pll_src_o,
   input wire logic [1:0]  main_src_o,
   input wire logic        pll_in_tick_o,
   input wire logic        main_tick_o,
   input wire logic        sys_tick_o,
   input wire logic        core_tick_o,
   input wire logic        rom_tick_o,
   input wire logic        ram_tick_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_taken |=> wb_ack_o)
      else $error("request not answered");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_main_hold: assert property (
      !$stable(main_src_o) |-> wb_ack_o)
      else $error("main source moved without update");
   a_pll_hold: assert property (
      !$stable(pll_src_o) |-> wb_ack_o)
      else $error("pll input moved without update");
   a_pll_none: assert property (
      pll_src_o[1] && $past(pll_src_o[1]) |-> !pll_in_tick_o)
      else $error("reserved pll input gave a tick");
   a_pll_rc: assert property (
      pll_src_o == 2'h0 && $past(pll_src_o) == 2'h0 && !$past(rst_i)
      |-> pll_in_tick_o == $past(rc_osc_tick_i))
      else $error("pll input does not follow rc");
   a_main_wd: assert property (
      main_src_o == 2'h2 && $past(main_src_o) == 2'h2 && !$past(rst_i)
      |-> main_tick_o == $past(wd_osc_tick_i))
      else $error("main tick does not follow watchdog");
   a_core_follow: assert property (
      !$past(rst_i) |-> core_tick_o == $past(sys_tick_o))
      else $error("core tick lost");
   a_gate_sub: assert property (
      rom_tick_o || ram_tick_o |-> $past(sys_tick_o))
      else $error("gated tick without system tick");
   a_sys_main: assert property (
      sys_tick_o |-> $past(main_tick_o))
      else $error("system tick without main tick");
endmodule
bind scg_top scg_top_asserts #(.DIV_W(DIV_W)) scg_top_asserts_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_osc_tick_i(rc_osc_tick_i),
   .wd_osc_tick_i(wd_osc_tick_i), .pll_src_o(pll_src_o),
   .main_src_o(main_src_o), .pll_in_tick_o(pll_in_tick_o),
   .main_tick_o(main_tick_o), .sys_tick_o(sys_tick_o),
   .core_tick_o(core_tick_o), .rom_tick_o(rom_tick_o),
   .ram_tick_o(ram_tick_o));
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench of the clock select and gating block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scg_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, r;
   logic [3:0]  wb_sel_i;
   logic        rc_osc_tick_i, sys_osc_tick_i, wd_osc_tick_i, pll_out_tick_i;
   logic [1:0]  pll_src_o, main_src_o;
   logic        pll_in_tick_o, main_tick_o, sys_tick_o, core_tick_o;
   logic        rom_tick_o, ram_tick_o, flash_reg_tick_o;
   logic [31:0] exp_q[$];
   int          fail_count, checks_done, cnt[5], s[5];
   integer      seed;
   int          dv[4] = '{3, 255, 0, 1};
   scg_top scg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rc_osc_tick_i(rc_osc_tick_i),
      .sys_osc_tick_i(sys_osc_tick_i), .wd_osc_tick_i(wd_osc_tick_i),
      .pll_out_tick_i(pll_out_tick_i), .pll_src_o(pll_src_o),
      .main_src_o(main_src_o), .pll_in_tick_o(pll_in_tick_o),
      .main_tick_o(main_tick_o), .sys_tick_o(sys_tick_o),
      .core_tick_o(core_tick_o), .rom_tick_o(rom_tick_o),
      .ram_tick_o(ram_tick_o), .flash_reg_tick_o(flash_reg_tick_o));
   always #12.5 clk_i = ~clk_i;
   // slow sources tick at random, rc ticks every cycle; all keep running
   always @(posedge clk_i) begin
      sys_osc_tick_i <= 1'($random(seed));
      wd_osc_tick_i <= 1'($random(seed));
      pll_out_tick_i <= 1'($random(seed));
   end
   // read results and tick counts
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         r = exp_q.pop_front();
         checks_done++;
         if (wb_dat_o !== r) begin
            fail_count++;
            $display("MISMATCH read data expected %h seen %h", r, wb_dat_o);
         end
      end
      cnt[0] += int'(sys_tick_o === 1'b1);
      cnt[1] += int'(core_tick_o === 1'b1);
      cnt[2] += int'(rom_tick_o === 1'b1 || ram_tick_o === 1'b1);
      cnt[3] += int'(flash_reg_tick_o === 1'b1);
      cnt[4] += int'(pll_in_tick_o === 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic we, input logic [31:0] a, d);
      int t;
      t = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 20);
      if (t == 20) fail_count++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [31:0] a, e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic report_and_stop;
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      seed = 32'hC563F840;
      {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, rst_i} = 5'h01;
      {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
      {rc_osc_tick_i, sys_osc_tick_i, wd_osc_tick_i, pll_out_tick_i} = 4'h8;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_sel_i <= 4'hF;
      rd(SCG_OFF_PLL_CHOICE, 32'h0);
      rd(SCG_OFF_PLL_UPDATE, 32'h0);
      rd(SCG_OFF_MAIN_CHOICE, 32'h0);
      rd(SCG_OFF_MAIN_UPDATE, 32'h0);
      rd(SCG_OFF_SYS_DIV, 32'h1);
      rd(SCG_OFF_GATES, 32'hF);
      rd(SCG_BASE, 32'h0);
      foreach (dv[i]) begin
         wb(1'b1, SCG_OFF_SYS_DIV, dv[i]);
         repeat (300) @(posedge clk_i);
         s = cnt;
         repeat (6 * (dv[i] == 0 ? 1 : dv[i])) @(posedge clk_i);
         chk("system ticks", (dv[i] == 0) ? 0 : 6, cnt[0] - s[0]);
         chk("core ticks", (dv[i] == 0) ? 0 : 6, cnt[1] - s[1]);
      end
      wb(1'b1, SCG_OFF_GATES, 32'h8);
      repeat (4) @(posedge clk_i);
      s = cnt;
      repeat (6) @(posedge clk_i);
      chk("rom ram ticks", 0, cnt[2] - s[2]);
      chk("core ticks", 6, cnt[1] - s[1]);
      chk("flash ticks", 6, cnt[3] - s[3]);
      rd(SCG_OFF_GATES, 32'h9);
      r = $random(seed);
      // system oscillator chosen as pll input, with random upper bits
      wb(1'b1, SCG_OFF_PLL_CHOICE, {r[31:2], 2'h1});
      chk("pll input", 0, 32'(pll_src_o));
      rd(SCG_OFF_PLL_CHOICE, 32'h1);
      wb(1'b1, SCG_OFF_PLL_UPDATE, 32'h0);
      wb(1'b1, SCG_OFF_PLL_UPDATE, {r[31:1], 1'b1});
      chk("pll input", 1, 32'(pll_src_o));
      rd(SCG_OFF_PLL_UPDATE, 32'h1);
      wb(1'b1, SCG_OFF_MAIN_CHOICE, 32'h2);
      chk("main source", 0, 32'(main_src_o));
      wb(1'b1, SCG_OFF_MAIN_UPDATE, 32'h0);
      wb(1'b1, SCG_OFF_MAIN_UPDATE, 32'h1);
      chk("main source", 2, 32'(main_src_o));
      repeat (50) @(posedge clk_i);
      wb(1'b1, SCG_OFF_MAIN_CHOICE, 32'h3);
      wb(1'b1, SCG_OFF_MAIN_UPDATE, 32'h1);
      chk("main source", 2, 32'(main_src_o));
      wb(1'b1, SCG_OFF_MAIN_UPDATE, 32'h0);
      wb(1'b1, SCG_OFF_MAIN_UPDATE, 32'h1);
      chk("main source", 3, 32'(main_src_o));
      // reserved pll input code gives no pll input tick
      wb(1'b1, SCG_OFF_PLL_CHOICE, 32'h2);
      wb(1'b1, SCG_OFF_PLL_UPDATE, 32'h0);
      wb(1'b1, SCG_OFF_PLL_UPDATE, 32'h1);
      chk("pll input", 2, 32'(pll_src_o));
      rd(SCG_OFF_PLL_CHOICE, 32'h2);
      repeat (2) @(posedge clk_i);
      s = cnt;
      repeat (20) @(posedge clk_i);
      chk("pll input ticks", 0, cnt[4] - s[4]);
      report_and_stop();
   end
endmodule
`default_nettype wire
